// ==== hw/dtmc_consts.svh ====
`ifndef DTMC_CONSTS_SVH
`define DTMC_CONSTS_SVH

// register indices; byte address is four times the index
`define DTMC_IDX_CTRL      10'h088
`define DTMC_IDX_MODE      10'h089
`define DTMC_IDX_A_LO      10'h08a
`define DTMC_IDX_B_LO      10'h08b
`define DTMC_IDX_A_HI      10'h08c
`define DTMC_IDX_B_HI      10'h08d
`define DTMC_IDX_IRQ_STAT  10'h090
`define DTMC_IDX_IRQ_MASK  10'h091

// control register fields
`define DTMC_CTRL_FLAG_B   7
`define DTMC_CTRL_RUN_B    6
`define DTMC_CTRL_FLAG_A   5
`define DTMC_CTRL_RUN_A    4

// mode register fields
`define DTMC_MODE_GATE_B   7
`define DTMC_MODE_SRC_B    6
`define DTMC_MODE_B_HI     5
`define DTMC_MODE_B_LO     4
`define DTMC_MODE_GATE_A   3
`define DTMC_MODE_SRC_A    2
`define DTMC_MODE_A_HI     1
`define DTMC_MODE_A_LO     0

// reset values
`define DTMC_CNT_RST       8'h00
`define DTMC_MODE_RST      8'h00
`define DTMC_IRQ_RST       2'h0

// system clock division for interval timing
`define DTMC_CLK_DIV       12

`endif

// ==== hw/dtmc_pkg.sv ====
package dtmc_pkg;

	typedef enum logic [1:0]
	{
		DTMC_MODE_PRESCALED = 2'h0,
		DTMC_MODE_WIDE      = 2'h1,
		DTMC_MODE_RELOAD    = 2'h2,
		DTMC_MODE_SPLIT     = 2'h3
	} dtmc_mode_e;

	typedef logic [7:0] dtmc_byte_t;

endpackage

// ==== hw/dtmc_pin_sync.sv ====
`timescale 1ns/10ps
module dtmc_pin_sync
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pin
	input  wire logic pin_i,
	// synchronised view
	output logic      level_o,
	output logic      fall_o
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= pin_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level_o = sync;
	assign fall_o  = prev & ~sync;
endmodule

// ==== hw/dtmc_timer.sv ====
// Function
// - gate clear: count whenever run bit set
// - gate set: count only with run and pin high
// - timer source: count divided system clock
// - counter source: count falling edges on event pin
// - mode 0: 8-bit high with 5-bit prescaler
// - mode 1: full 16-bit counter
// - unit b mode 2: low reloads from high
// - unit a mode 2: low reloads from high
// - unit b mode 3: halted, count held
// - count bytes eight bits, zero after reset
// - overflow sets flag, vectoring clears it
// - reload leaves the high byte unchanged
// - unit b mode 3 halts when run borrowed
`timescale 1ns/10ps
`include "dtmc_consts.svh"
module dtmc_timer
	import dtmc_pkg::*;
#(
	parameter int CLK_DIV = `DTMC_CLK_DIV
)
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// external pins
	input  wire logic        unit_a_gate_pin_i,
	input  wire logic        unit_b_gate_pin_i,
	input  wire logic        unit_a_event_pin_i,
	input  wire logic        unit_b_event_pin_i,
	// interrupt vectoring acknowledge
	input  wire logic        unit_a_vector_i,
	input  wire logic        unit_b_vector_i,
	// flags and interrupt
	output logic             unit_a_overflow_flag_o,
	output logic             unit_b_overflow_flag_o,
	output logic             irq_o
);
	localparam int PW = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
	localparam int TDIV = CLK_DIV - 1;

	dtmc_byte_t mode_reg;
	dtmc_byte_t cnt_a_lo;
	dtmc_byte_t cnt_a_hi;
	dtmc_byte_t cnt_b_lo;
	dtmc_byte_t cnt_b_hi;
	logic       run_a;
	logic       run_b;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [PW-1:0] pre_cnt;
	logic       pre_tick;

	// pins: gate a, gate b, event a, event b
	logic [3:0] pin_raw;
	logic [3:0] pin_lvl;
	logic [3:0] pin_fall;

	assign pin_raw = {unit_b_event_pin_i, unit_a_event_pin_i,
		unit_b_gate_pin_i, unit_a_gate_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			dtmc_pin_sync u_sync
			(
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.pin_i   (pin_raw[gi]),
				.level_o (pin_lvl[gi]),
				.fall_o  (pin_fall[gi])
			);
		end
	endgenerate

	// bus decode
	wire [9:0] idx     = wb_adr_i[11:2];
	wire       req     = wb_cyc_i & wb_stb_i;
	wire       wr_en   = req & wb_we_i & wb_sel_i[0] & wb_ack_o;
	wire [7:0] wdat    = wb_dat_i[7:0];
	wire       wr_ctrl = wr_en & (idx == `DTMC_IDX_CTRL);
	wire       wr_mode = wr_en & (idx == `DTMC_IDX_MODE);
	wire       wr_a_lo = wr_en & (idx == `DTMC_IDX_A_LO);
	wire       wr_a_hi = wr_en & (idx == `DTMC_IDX_A_HI);
	wire       wr_b_lo = wr_en & (idx == `DTMC_IDX_B_LO);
	wire       wr_b_hi = wr_en & (idx == `DTMC_IDX_B_HI);
	wire       wr_ist  = wr_en & (idx == `DTMC_IDX_IRQ_STAT);
	wire       wr_imsk = wr_en & (idx == `DTMC_IDX_IRQ_MASK);

	// mode fields
	wire        gate_a = mode_reg[`DTMC_MODE_GATE_A];
	wire        gate_b = mode_reg[`DTMC_MODE_GATE_B];
	wire        src_a  = mode_reg[`DTMC_MODE_SRC_A];
	wire        src_b  = mode_reg[`DTMC_MODE_SRC_B];
	wire dtmc_mode_e mode_a = dtmc_mode_e'(
		{mode_reg[`DTMC_MODE_A_HI], mode_reg[`DTMC_MODE_A_LO]});
	wire dtmc_mode_e mode_b = dtmc_mode_e'(
		{mode_reg[`DTMC_MODE_B_HI], mode_reg[`DTMC_MODE_B_LO]});

	// count enables
	wire src_tick_a = src_a ? pin_fall[2] : pre_tick;
	wire src_tick_b = src_b ? pin_fall[3] : pre_tick;
	wire gate_ok_a  = ~gate_a | pin_lvl[0];
	wire gate_ok_b  = ~gate_b | pin_lvl[1];
	// run bit b is taken by the split high byte; b then free-runs
	wire borrowed   = (mode_a == DTMC_MODE_SPLIT);
	wire run_b_eff  = borrowed | run_b;
	wire inc_a      = run_a & gate_ok_a & src_tick_a;
	wire inc_b      = (mode_b != DTMC_MODE_SPLIT) & run_b_eff &
		gate_ok_b & src_tick_b;
	wire inc_ah     = borrowed & run_b & pre_tick;

	function automatic logic [16:0] count_step(input dtmc_mode_e m,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h1;
		s16 = {1'b0, hi, lo} + 17'h1;
		s8  = {1'b0, lo} + 9'h1;
		unique case (m)
			DTMC_MODE_PRESCALED:
				count_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			DTMC_MODE_WIDE:
				count_step = s16;
			DTMC_MODE_RELOAD:
				count_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			DTMC_MODE_SPLIT:
				count_step = {s8[8], hi, s8[7:0]};
		endcase
		return count_step;
	endfunction

	wire [16:0] step_a = count_step(mode_a, cnt_a_hi, cnt_a_lo);
	wire [16:0] step_b = count_step(mode_b, cnt_b_hi, cnt_b_lo);
	wire [7:0]  ah_inc = cnt_a_hi + 8'h1;

	// a software write in the same cycle overrides the count
	wire [7:0] next_a_lo = wr_a_lo ? wdat : inc_a ? step_a[7:0] : cnt_a_lo;
	wire [7:0] next_a_hi = wr_a_hi ? wdat :
		(inc_a & ~borrowed) ? step_a[15:8] :
		inc_ah ? ah_inc : cnt_a_hi;
	wire [7:0] next_b_lo = wr_b_lo ? wdat : inc_b ? step_b[7:0] : cnt_b_lo;
	wire [7:0] next_b_hi = wr_b_hi ? wdat : inc_b ? step_b[15:8] : cnt_b_hi;

	// overflow events; b overflow is not flagged while its bits are lent
	wire ovf_a  = inc_a & step_a[16];
	wire ovf_ah = inc_ah & (&cnt_a_hi);
	wire ovf_b  = inc_b & step_b[16] & ~borrowed;
	wire set_a  = ovf_a;
	wire set_b  = ovf_b | ovf_ah;

	// hardware set wins over vector clear and software write
	wire next_flag_a = set_a | (wr_ctrl ? wdat[`DTMC_CTRL_FLAG_A] :
		unit_a_overflow_flag_o & ~unit_a_vector_i);
	wire next_flag_b = set_b | (wr_ctrl ? wdat[`DTMC_CTRL_FLAG_B] :
		unit_b_overflow_flag_o & ~unit_b_vector_i);
	wire [1:0] next_irq_stat = {set_b, set_a} |
		(irq_stat & ~(wr_ist ? wdat[1:0] : 2'h0));

	// read mux
	wire [7:0] ctrl_rd = {unit_b_overflow_flag_o, run_b,
		unit_a_overflow_flag_o, run_a, 4'h0};
	wire [7:0] rdata =
		(idx == `DTMC_IDX_CTRL)     ? ctrl_rd :
		(idx == `DTMC_IDX_MODE)     ? mode_reg :
		(idx == `DTMC_IDX_A_LO)     ? cnt_a_lo :
		(idx == `DTMC_IDX_A_HI)     ? cnt_a_hi :
		(idx == `DTMC_IDX_B_LO)     ? cnt_b_lo :
		(idx == `DTMC_IDX_B_HI)     ? cnt_b_hi :
		(idx == `DTMC_IDX_IRQ_STAT) ? {6'h00, irq_stat} :
		(idx == `DTMC_IDX_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

	wire pre_wrap = (pre_cnt == PW'(CLK_DIV - 1));

	// prescaler
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pre_cnt  <= '0;
			pre_tick <= 1'b0;
		end
		else
		begin
			pre_cnt  <= pre_wrap ? '0 : pre_cnt + PW'(1);
			pre_tick <= pre_wrap;
		end
	end

	// bus slave: one wait state, unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= {24'h00_0000, rdata};
		end
	end

	// registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_reg               <= `DTMC_MODE_RST;
			cnt_a_lo               <= `DTMC_CNT_RST;
			cnt_a_hi               <= `DTMC_CNT_RST;
			cnt_b_lo               <= `DTMC_CNT_RST;
			cnt_b_hi               <= `DTMC_CNT_RST;
			run_a                  <= 1'b0;
			run_b                  <= 1'b0;
			unit_a_overflow_flag_o <= 1'b0;
			unit_b_overflow_flag_o <= 1'b0;
			irq_stat               <= `DTMC_IRQ_RST;
			irq_mask               <= `DTMC_IRQ_RST;
			irq_o                  <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= wdat;
			if (wr_ctrl)
			begin
				run_a <= wdat[`DTMC_CTRL_RUN_A];
				run_b <= wdat[`DTMC_CTRL_RUN_B];
			end
			if (wr_imsk)
				irq_mask <= wdat[1:0];
			cnt_a_lo               <= next_a_lo;
			cnt_a_hi               <= next_a_hi;
			cnt_b_lo               <= next_b_lo;
			cnt_b_hi               <= next_b_hi;
			unit_a_overflow_flag_o <= next_flag_a;
			unit_b_overflow_flag_o <= next_flag_b;
			irq_stat               <= next_irq_stat;
			irq_o                  <= |(irq_stat & irq_mask);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ovf_a;
		inc_a && step_a[16] && !wr_en;
	endsequence

	sequence s_flag_stays_a;
		unit_a_overflow_flag_o && !unit_a_vector_i && !wr_en;
	endsequence

	chk_gate_free: assert property (
		(!gate_a && run_a && src_tick_a && mode_a == DTMC_MODE_WIDE
			&& !wr_en)
		|=> {cnt_a_hi, cnt_a_lo} == $past({cnt_a_hi, cnt_a_lo}) + 16'h1)
		else $error("ungated unit a did not count");

	chk_gate_hold: assert property (
		(gate_a && !pin_lvl[0] && !borrowed && !wr_en)
		|=> $stable(cnt_a_lo) && $stable(cnt_a_hi))
		else $error("gated unit a counted with gate low");

	chk_timer_rate: assert property (
		pre_tick |=> !pre_tick ##[TDIV:TDIV] pre_tick)
		else $error("prescaler tick spacing wrong");

	chk_event_edge: assert property (
		(src_b && !gate_b && run_b && !borrowed && !wr_en && !pin_fall[3])
		|=> $stable(cnt_b_lo))
		else $error("unit b counted without a falling edge");

	chk_prescale_carry: assert property (
		(mode_a == DTMC_MODE_PRESCALED && inc_a
			&& cnt_a_lo[4:0] == 5'h1f && !wr_en)
		|=> cnt_a_lo[4:0] == 5'h00 && cnt_a_hi == $past(cnt_a_hi) + 8'h1)
		else $error("prescaler carry into high byte missed");

	chk_reload_b: assert property (
		(mode_b == DTMC_MODE_RELOAD && inc_b && cnt_b_lo == 8'hff
			&& !wr_en && !borrowed)
		|=> cnt_b_lo == $past(cnt_b_hi) && $stable(cnt_b_hi)
			&& unit_b_overflow_flag_o)
		else $error("unit b reload wrong");

	chk_reload_a: assert property (
		(mode_a == DTMC_MODE_RELOAD && inc_a && cnt_a_lo == 8'hff && !wr_en)
		|=> cnt_a_lo == $past(cnt_a_hi) && $stable(cnt_a_hi))
		else $error("unit a reload wrong");

	chk_halt_b: assert property (
		(mode_b == DTMC_MODE_SPLIT && !wr_en)
		|=> $stable(cnt_b_lo) && $stable(cnt_b_hi))
		else $error("halted unit b changed its count");

	chk_reset_zero: assert property (
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> cnt_a_lo == 8'h00 && cnt_a_hi == 8'h00
			&& cnt_b_lo == 8'h00 && cnt_b_hi == 8'h00)
		else $error("count bytes not zero after reset");

	chk_split_high: assert property (
		(borrowed && run_b && pre_tick && !wr_en)
		|=> cnt_a_hi == $past(cnt_a_hi) + 8'h1)
		else $error("split high byte did not count");

	chk_mode_write: assert property (
		wr_mode |=> mode_reg == $past(wdat) ##1 wb_dat_o[7:0] == mode_reg
			|| idx != `DTMC_IDX_MODE)
		else $error("mode register write lost");

	chk_flag_set: assert property (
		s_ovf_a |=> unit_a_overflow_flag_o ##0 s_flag_stays_a
			|=> unit_a_overflow_flag_o)
		else $error("unit a overflow flag not held");

	chk_flag_vector: assert property (
		(unit_a_vector_i && !ovf_a && !wr_en) |=> !unit_a_overflow_flag_o)
		else $error("vectoring did not clear unit a flag");

	chk_irq_level: assert property (
		(|(irq_stat & irq_mask)) |=> irq_o)
		else $error("interrupt output missed a masked status bit");
endmodule

// ==== verification/dtmc_pins.sv ====
`timescale 1ns/10ps
module dtmc_pins
(
	// clock
	input  wire logic clk_i,
	// pins towards the block
	output logic      gate_a_o,
	output logic      gate_b_o,
	output logic      event_a_o,
	output logic      event_b_o
);
	initial
	begin
		gate_a_o = 1'b0;
		gate_b_o = 1'b0;
		event_a_o = 1'b1;
		event_b_o = 1'b1;
	end

	// low held len clocks, high len plus one between pulses; the synchroniser needs two
	task automatic pulse(input bit unit_b, input int n, input int len);
		repeat (n)
		begin
			@(posedge clk_i);
			if (unit_b)
				event_b_o <= 1'b0;
			else
				event_a_o <= 1'b0;
			repeat (len) @(posedge clk_i);
			event_a_o <= 1'b1;
			event_b_o <= 1'b1;
			repeat (len) @(posedge clk_i);
		end
	endtask

	task automatic gate(input bit unit_b, input logic lvl);
		@(posedge clk_i);
		if (unit_b)
			gate_b_o <= lvl;
		else
			gate_a_o <= lvl;
	endtask
endmodule

// ==== verification/dual_timer_mode_control_bench.sv ====
`timescale 1ns/10ps
`include "dtmc_consts.svh"
module dual_timer_mode_control_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        ga, gb, ea, eb;
	logic        vec_a = 1'b0;
	logic        vec_b = 1'b0;
	logic        flag_a, flag_b, irq;
	logic [15:0] expq[$];
	logic [15:0] e;
	logic [7:0]  last_rd;
	logic [7:0]  hi_seen;
	logic [31:0] lfsr = 32'h1f99;
	int          miscompares = 0;
	int          checks_done = 0;

	always #2.5 clk_i = ~clk_i;

	dtmc_pins pins_u (.clk_i(clk_i), .gate_a_o(ga), .gate_b_o(gb),
		.event_a_o(ea), .event_b_o(eb));

	dtmc_timer #(.CLK_DIV(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .unit_a_gate_pin_i(ga), .unit_b_gate_pin_i(gb),
		.unit_a_event_pin_i(ea), .unit_b_event_pin_i(eb),
		.unit_a_vector_i(vec_a), .unit_b_vector_i(vec_b),
		.unit_a_overflow_flag_o(flag_a), .unit_b_overflow_flag_o(flag_b),
		.irq_o(irq));

	function automatic logic [31:0] next_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic close_out();
		$display("compares %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a read pushes its expectation; mask 0 means take the value only
	task automatic bus(input logic w, input logic [9:0] idx,
		input logic [7:0] d, input logic [7:0] m);
		if (!w)
			expq.push_back({m, d});
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		last_rd = rdat[7:0];
		cyc <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 8'h00);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b0, idx, d, 8'hff);
	endtask

	always @(posedge clk_i)
	begin
		if (ack === 1'b1 && cyc && !we && expq.size() > 0)
		begin
			e = expq.pop_front();
			if (e[15:8] != 8'h00)
				chk(rdat[7:0] & e[15:8], e[7:0]);
		end
	end

	initial
	begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		close_out();
	end

	task automatic vector_a();
		@(posedge clk_i);
		vec_a <= 1'b1;
		@(posedge clk_i);
		vec_a <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`DTMC_IDX_MODE, 8'h00);
		rd(`DTMC_IDX_A_LO, 8'h00);
		rd(`DTMC_IDX_A_HI, 8'h00);
		rd(`DTMC_IDX_B_LO, 8'h00);
		rd(`DTMC_IDX_B_HI, 8'h00);
		rd(10'h0a0, 8'h00);
		repeat (4)
		begin
			lfsr = next_lfsr(lfsr);
			wr(`DTMC_IDX_MODE, lfsr[7:0]);
			rd(`DTMC_IDX_MODE, lfsr[7:0]);
		end
		// gate select clear, gate pin low: counts anyway, carry to high
		wr(`DTMC_IDX_A_LO, 8'hfe);
		wr(`DTMC_IDX_A_HI, 8'h00);
		wr(`DTMC_IDX_MODE, 8'h05);
		wr(`DTMC_IDX_CTRL, 8'h10);
		pins_u.pulse(1'b0, 3, 3);
		rd(`DTMC_IDX_A_LO, 8'h01);
		rd(`DTMC_IDX_A_HI, 8'h01);
		// gated: pin low blocks, pin high passes
		wr(`DTMC_IDX_MODE, 8'h0d);
		wr(`DTMC_IDX_A_LO, 8'h00);
		pins_u.pulse(1'b0, 2, 2);
		rd(`DTMC_IDX_A_LO, 8'h00);
		pins_u.gate(1'b0, 1'b1);
		pins_u.pulse(1'b0, 2, 4);
		rd(`DTMC_IDX_A_LO, 8'h02);
		// prescaled: low five bits roll into high, top three held
		wr(`DTMC_IDX_MODE, 8'h04);
		wr(`DTMC_IDX_A_HI, 8'h00);
		wr(`DTMC_IDX_A_LO, 8'hff);
		pins_u.pulse(1'b0, 1, 3);
		rd(`DTMC_IDX_A_LO, 8'he0);
		rd(`DTMC_IDX_A_HI, 8'h01);
		// auto-reload on unit a, overflow raises flag and interrupt
		wr(`DTMC_IDX_IRQ_MASK, 8'h01);
		wr(`DTMC_IDX_A_HI, 8'hf0);
		wr(`DTMC_IDX_A_LO, 8'hfe);
		wr(`DTMC_IDX_MODE, 8'h06);
		pins_u.pulse(1'b0, 3, 3);
		rd(`DTMC_IDX_A_LO, 8'hf1);
		rd(`DTMC_IDX_A_HI, 8'hf0);
		chk({7'h0, flag_a}, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(`DTMC_IDX_IRQ_STAT, 8'h01);
		vector_a();
		chk({7'h0, flag_a}, 8'h00);
		wr(`DTMC_IDX_IRQ_STAT, 8'h01);
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq}, 8'h00);
		// unit b reload, then mode 3 holds the count
		wr(`DTMC_IDX_B_HI, 8'h80);
		wr(`DTMC_IDX_B_LO, 8'hff);
		wr(`DTMC_IDX_MODE, 8'h60);
		wr(`DTMC_IDX_CTRL, 8'h40);
		pins_u.pulse(1'b1, 2, 3);
		rd(`DTMC_IDX_B_LO, 8'h81);
		chk({7'h0, flag_b}, 8'h01);
		wr(`DTMC_IDX_MODE, 8'h70);
		pins_u.pulse(1'b1, 3, 3);
		rd(`DTMC_IDX_B_LO, 8'h81);
		rd(`DTMC_IDX_B_HI, 8'h80);
		// interval timer: about one tick per four clocks
		wr(`DTMC_IDX_MODE, 8'h01);
		wr(`DTMC_IDX_A_LO, 8'h00);
		wr(`DTMC_IDX_CTRL, 8'h10);
		repeat (40) @(posedge clk_i);
		wr(`DTMC_IDX_CTRL, 8'h00);
		bus(1'b0, `DTMC_IDX_A_LO, 8'h00, 8'h00);
		chk({7'h0, last_rd >= 8'd10 && last_rd <= 8'd11}, 8'h01);
		// split unit a: high byte runs on unit b's run bit, b halted
		wr(`DTMC_IDX_A_HI, 8'h00);
		wr(`DTMC_IDX_A_LO, 8'h20);
		wr(`DTMC_IDX_B_LO, 8'h10);
		wr(`DTMC_IDX_MODE, 8'h33);
		wr(`DTMC_IDX_CTRL, 8'h40);
		repeat (20) @(posedge clk_i);
		wr(`DTMC_IDX_CTRL, 8'h00);
		bus(1'b0, `DTMC_IDX_A_HI, 8'h00, 8'h00);
		hi_seen = last_rd;
		chk({7'h0, hi_seen >= 8'd5 && hi_seen <= 8'd6}, 8'h01);
		rd(`DTMC_IDX_A_LO, 8'h20);
		rd(`DTMC_IDX_B_LO, 8'h10);
		// low byte alone under unit a's run bit, high byte held
		wr(`DTMC_IDX_CTRL, 8'h10);
		repeat (20) @(posedge clk_i);
		wr(`DTMC_IDX_CTRL, 8'h00);
		rd(`DTMC_IDX_A_HI, hi_seen);
		bus(1'b0, `DTMC_IDX_A_LO, 8'h00, 8'h00);
		chk({7'h0, last_rd >= 8'h25 && last_rd <= 8'h26}, 8'h01);
		close_out();
	end
endmodule
